// ### shared/idle_domain_control_defs.svh
// Register offsets, field positions, reset values and widths for idle control.
`ifndef IDLE_DOMAIN_CONTROL_DEFS_SVH
`define IDLE_DOMAIN_CONTROL_DEFS_SVH
// Register indices; the byte address is four times the index.
`define IDC_IDX_CONFIG 16'h0001
`define IDC_IDX_STATUS 16'h0002
`define IDC_IDX_PERIPH_CTRL 16'h9400
`define IDC_IDX_PERIPH_STAT 16'h9401
`define IDC_IDX_MASTER_CTRL 16'h9402
`define IDC_IDX_MASTER_STAT 16'h9403
// Extra registers: idle strobe, bus selection and event flags.
`define IDC_IDX_COMMAND 16'h0010
`define IDC_IDX_BUS_SELECT 16'h0011
`define IDC_IDX_EVENTS 16'h0012
// Field positions in the idle configuration register.
`define IDC_BIT_CPU 0
`define IDC_BIT_MASTER 1
`define IDC_BIT_CACHE 2
`define IDC_BIT_PERIPH 3
`define IDC_BIT_CLOCKGEN 4
`define IDC_BIT_MEMIF 5
`define IDC_BIT_IOPORT 6
`define IDC_BIT_DMAPORT 7
`define IDC_BIT_FETCH 8
`define IDC_BIT_CLKEXT 9
// Writable bits of the configuration; bits 15 to 10 read zero.
`define IDC_CONFIG_MASK 16'h03ff
// Bits that must all be set for a valid clock generator idle.
`define IDC_DEEP_MASK 16'h03f7
// Master control field positions.
`define IDC_MBIT_DMA 0
`define IDC_MBIT_HOST 1
// Bus selection bit that routes the bus to the memory interface.
`define IDC_XBIT_MEMIF 0
// Reset values.
`define IDC_RESET_WORD 16'h0000
`define IDC_RESET_SELECT 16'h0001
// Clock restart settle count in cycles.
`define IDC_RESTART_CYCLES 4
`endif

// ### shared/idle_domain_control_pkg.sv
// Types shared by the idle domain controller.
package idle_domain_control_pkg;
    // Phases of the power state machine.
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_IDLE = 2'b01,
        ST_DEEP = 2'b11,
        ST_WAKE = 2'b10
    } power_state_t;
    // One register access request toward the register file.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] index;
        logic [15:0] wdata;
        logic [1:0] strb;
    } reg_req_t;
endpackage : idle_domain_control_pkg

// ### verilog/clock_gate_cell.sv
// Glitch free clock gate: enable latched while the clock is low.
`timescale 1ns/1ps
module clock_gate_cell (
    input wire logic i_clock,
    input wire logic i_enable,
    output logic o_gated_clock
);
    // The latch holds the enable steady across the high phase.
    logic enable_latch;

    // Transparent while the clock is low, so no partial pulse appears.
    always_latch begin
        if (!i_clock) begin
            enable_latch = i_enable;
        end
    end

    // The gated clock is the clock qualified by the held enable.
    assign o_gated_clock = i_clock & enable_latch;
endmodule : clock_gate_cell

// ### verilog/pin_sync3.sv
// Three stage synchroniser for pin inputs with agreement filter.
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    // Three stages; the first is only read by the second.
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    // Refuse a zero width bus.
    initial begin
        if (WIDTH < 1) begin
            $error("pin_sync3 width must be positive.");
        end
    end

    // Shift the pins through the chain.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Output changes per bit once stages two and three agree.
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge i_clock or negedge i_nrst) begin
                if (!i_nrst) begin
                    o_sync[g] <= 1'b0;
                end else if (s2_r[g] == s3_r[g]) begin
                    o_sync[g] <= s3_r[g];
                end
            end
        end
    endgenerate
endmodule : pin_sync3

// ### verilog/idle_domain_control.sv
// Idle domain controller with AXI4-Lite registers and clock gates.
// Notes on behaviour
// - Running: status follows config only on idle.
// - Light idle: interrupt wakes, clears status bits.
// - Deep idle: external interrupt or reset wakes.
// - Serial transfer auto-wakes idled DMA master only.
// - Finished auto transfer returns DMA to idle.
// - Memory interface clock off when unselected.
// - Memory interface access while unselected or idled flags access error.
// - Control writes take effect at idle instruction.
// - Peripheral idle control and status registers.
// - Master idle control and status registers.
// - Config 16 bits, zero reset, bit layout.
// - Bit 9 extended clock; 15-10 read zero.
// - Bit 8 idles the fetch port.
// - Clock stops only with both clock bits.
// - Clock bit without extended bit: bus error.
// - Clock idle needs all deep bits set.
// - Valid clock idle stops the system clock.
// - PLL settings power core down at deep idle.
`timescale 1ns/1ps
`include "idle_domain_control_defs.svh"
module idle_domain_control
    import idle_domain_control_pkg::*;
#(
    parameter int PERIPH_WIDTH = 16
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    // AXI4-Lite slave.
    input wire logic [31:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [31:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // CPU signals on the same clock.
    input wire logic i_idle_instr,
    input wire logic i_unmasked_irq,
    input wire logic i_pll_powerdown_sel,
    // Pins from outside the clock domain.
    input wire logic i_ext_irq,
    input wire logic i_serial_frame,
    input wire logic i_serial_done,
    // Access attempt toward the memory interface.
    input wire logic i_memif_access,
    // Gated domain clocks, clock controls, error flags and idle outputs.
    output logic o_cpu_clock,
    output logic o_memif_clock,
    output logic o_sysclk_enable,
    output logic o_pll_powerdown,
    output logic o_bus_error_irq,
    output logic o_access_error,
    output logic [PERIPH_WIDTH-1:0] o_periph_idle,
    output logic [1:0] o_master_idle
);
    // Elaboration check on the peripheral width.
    initial begin
        if (PERIPH_WIDTH < 1 || PERIPH_WIDTH > 16) begin
            $error("PERIPH_WIDTH must lie between 1 and 16.");
        end
    end

    localparam int RESTART = `IDC_RESTART_CYCLES;

    // Register state.
    logic [15:0] config_r; // Idle configuration.
    logic [15:0] status_r; // Idle status.
    logic [15:0] pctrl_r; // Peripheral idle control.
    logic [15:0] pstat_r; // Peripheral idle status.
    logic [15:0] mctrl_r; // Master idle control.
    logic [15:0] mstat_r; // Master idle status.
    logic [15:0] xsel_r; // External bus selection.
    logic auto_r; // Serial auto-wake transfer in flight.
    logic buserr_r; // Sticky invalid idle flag.
    logic accerr_r; // Sticky disabled module access flag.
    power_state_t state_r;
    logic [2:0] wake_cnt_r; // Restart settle counter.
    logic ext_irq_s;
    logic frame_s;
    logic done_s;

    // Synchronise the asynchronous pins.
    pin_sync3 #(
        .WIDTH(3)
    ) u_sync (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_async({i_ext_irq, i_serial_frame, i_serial_done}),
        .o_sync({ext_irq_s, frame_s, done_s})
    );

    // Bus write path: hold address and data until both have arrived.
    logic aw_have_r;
    logic w_have_r;
    logic [15:0] aw_idx_r;
    logic [31:0] wd_r;
    logic [3:0] ws_r;
    reg_req_t wreq;
    logic do_write;

    // Ready while the slot is empty and no response is pending.
    assign o_awready = !aw_have_r && !o_bvalid;
    assign o_wready = !w_have_r && !o_bvalid;
    assign do_write = aw_have_r && w_have_r && !o_bvalid;

    // Capture address and data independently in either order.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_idx_r <= 16'h0000;
            wd_r <= 32'h0000_0000;
            ws_r <= 4'h0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_have_r <= 1'b1;
                aw_idx_r <= i_awaddr[17:2];
            end else if (do_write) begin
                aw_have_r <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_have_r <= 1'b1;
                wd_r <= i_wdata;
                ws_r <= i_wstrb;
            end else if (do_write) begin
                w_have_r <= 1'b0;
            end
        end
    end

    // Form the write request from the captured halves.
    always_comb begin
        wreq.wr = do_write;
        wreq.rd = 1'b0;
        wreq.index = aw_idx_r;
        wreq.wdata = wd_r[15:0];
        wreq.strb = ws_r[1:0];
    end

    // Merge byte lanes into a 16-bit register value.
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input reg_req_t rq);
        logic [15:0] v;
        v = old;
        if (rq.strb[0]) begin
            v[7:0] = rq.wdata[7:0];
        end
        if (rq.strb[1]) begin
            v[15:8] = rq.wdata[15:8];
        end
        return v;
    endfunction : merge

    // Decode whether an index is mapped.
    function automatic logic mapped(input logic [15:0] idx);
        return idx == `IDC_IDX_CONFIG || idx == `IDC_IDX_STATUS ||
               idx == `IDC_IDX_PERIPH_CTRL || idx == `IDC_IDX_PERIPH_STAT ||
               idx == `IDC_IDX_MASTER_CTRL || idx == `IDC_IDX_MASTER_STAT ||
               idx == `IDC_IDX_COMMAND || idx == `IDC_IDX_BUS_SELECT ||
               idx == `IDC_IDX_EVENTS;
    endfunction : mapped

    // Write response: OKAY for mapped, SLVERR for unmapped.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_bvalid <= 1'b0;
            o_bresp <= 2'b00;
        end else if (do_write) begin
            o_bvalid <= 1'b1;
            o_bresp <= mapped(wreq.index) ? 2'b00 : 2'b10;
        end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // Software idle command: a write of bit 0 to the command register.
    logic sw_idle;
    assign sw_idle = wreq.wr && wreq.index == `IDC_IDX_COMMAND &&
                     wreq.strb[0] && wreq.wdata[0];

    // Idle instruction from either the CPU strobe or the command.
    logic idle_go;
    assign idle_go = (i_idle_instr || sw_idle) && state_r == ST_RUN;

    // Validity of a clock generator request.
    logic clk_req;
    logic clk_valid;
    assign clk_req = config_r[`IDC_BIT_CLOCKGEN];
    // Both clock bits plus every deep bit must be set.
    assign clk_valid = (config_r & `IDC_DEEP_MASK) == `IDC_DEEP_MASK;

    // Control registers take software writes only; nothing idles here.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            config_r <= `IDC_RESET_WORD;
            pctrl_r <= `IDC_RESET_WORD;
            mctrl_r <= `IDC_RESET_WORD;
            xsel_r <= `IDC_RESET_SELECT;
        end else if (wreq.wr) begin
            if (wreq.index == `IDC_IDX_CONFIG) begin
                // Reserved bits stay zero.
                config_r <= merge(config_r, wreq) & `IDC_CONFIG_MASK;
            end
            if (wreq.index == `IDC_IDX_PERIPH_CTRL) begin
                pctrl_r <= merge(pctrl_r, wreq);
            end
            if (wreq.index == `IDC_IDX_MASTER_CTRL) begin
                mctrl_r <= merge(mctrl_r, wreq);
            end
            if (wreq.index == `IDC_IDX_BUS_SELECT) begin
                xsel_r <= merge(xsel_r, wreq);
            end
        end
    end

    // Wake conditions per idle depth.
    logic wake_light;
    logic wake_deep;
    assign wake_light = i_unmasked_irq || ext_irq_s;
    assign wake_deep = ext_irq_s;

    // Power state machine.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= ST_RUN;
            wake_cnt_r <= 3'h0;
        end else begin
            unique case (state_r)
                ST_RUN: begin
                    if (idle_go && clk_req && clk_valid) begin
                        state_r <= ST_DEEP;
                    end else if (idle_go && !clk_req &&
                                 config_r[`IDC_BIT_CPU]) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (wake_light) begin
                        state_r <= ST_WAKE;
                        wake_cnt_r <= 3'(RESTART);
                    end
                end
                ST_DEEP: begin
                    if (wake_deep) begin
                        state_r <= ST_WAKE;
                        wake_cnt_r <= 3'(RESTART);
                    end
                end
                ST_WAKE: begin
                    // Hold the CPU gate closed until the clocks settle.
                    if (wake_cnt_r == 3'h0) begin
                        state_r <= ST_RUN;
                    end else begin
                        wake_cnt_r <= wake_cnt_r - 3'h1;
                    end
                end
            endcase
        end
    end

    // Status registers: loaded at the idle instruction; wake clears some status_r bits.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            status_r <= `IDC_RESET_WORD;
            pstat_r <= `IDC_RESET_WORD;
            mstat_r <= `IDC_RESET_WORD;
        end else if (idle_go && !(clk_req && !clk_valid)) begin
            status_r <= config_r;
            pstat_r <= config_r[`IDC_BIT_PERIPH] ? pctrl_r : 16'h0000;
            mstat_r <= config_r[`IDC_BIT_MASTER] ? mctrl_r : 16'h0000;
        end else if ((state_r == ST_IDLE && wake_light) ||
                     (state_r == ST_DEEP && wake_deep)) begin
            // Config stays; CPU, clock, memory interface, I/O port and fetch status bits clear.
            status_r[`IDC_BIT_CPU] <= 1'b0;
            status_r[`IDC_BIT_CLOCKGEN] <= 1'b0;
            status_r[`IDC_BIT_CLKEXT] <= 1'b0;
            status_r[`IDC_BIT_MEMIF] <= 1'b0;
            status_r[`IDC_BIT_IOPORT] <= 1'b0;
            status_r[`IDC_BIT_FETCH] <= 1'b0;
        end
    end

    // Serial auto-wake of idled DMA master.
    logic dma_idle;
    assign dma_idle = mstat_r[`IDC_MBIT_DMA];
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            auto_r <= 1'b0;
        end else if (!auto_r && dma_idle && frame_s) begin
            auto_r <= 1'b1;
        end else if (auto_r && done_s) begin
            auto_r <= 1'b0;
        end
    end

    // Sticky error flags; a new event wins over the clear.
    logic ev_clr;
    logic mem_on;
    assign ev_clr = wreq.wr && wreq.index == `IDC_IDX_EVENTS;
    assign mem_on = xsel_r[`IDC_XBIT_MEMIF] && !status_r[`IDC_BIT_MEMIF];
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            buserr_r <= 1'b0;
            accerr_r <= 1'b0;
        end else begin
            if (idle_go && clk_req && !clk_valid) begin
                buserr_r <= 1'b1;
            end else if (ev_clr && wreq.strb[0] && wreq.wdata[0]) begin
                buserr_r <= 1'b0;
            end
            if (i_memif_access && !mem_on) begin
                accerr_r <= 1'b1;
            end else if (ev_clr && wreq.strb[0] && wreq.wdata[1]) begin
                accerr_r <= 1'b0;
            end
        end
    end

    // Read path with registered data.
    logic [15:0] rd_val;
    always_comb begin
        rd_val = 16'h0000;
        unique case (i_araddr[17:2])
            `IDC_IDX_CONFIG: rd_val = config_r;
            `IDC_IDX_STATUS: rd_val = status_r;
            `IDC_IDX_PERIPH_CTRL: rd_val = pctrl_r;
            `IDC_IDX_PERIPH_STAT: rd_val = pstat_r;
            `IDC_IDX_MASTER_CTRL: rd_val = mctrl_r;
            `IDC_IDX_MASTER_STAT: rd_val = {mstat_r[15:1], dma_idle && !auto_r};
            `IDC_IDX_BUS_SELECT: rd_val = xsel_r;
            `IDC_IDX_EVENTS: rd_val = {14'h0000, accerr_r, buserr_r};
            default: rd_val = 16'h0000;
        endcase
    end

    assign o_arready = !o_rvalid;
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= 2'b00;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rdata <= {16'h0000, rd_val};
            o_rresp <= mapped(i_araddr[17:2]) ? 2'b00 : 2'b10;
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    // Registered outputs toward the clock tree and domains.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_sysclk_enable <= 1'b1;
            o_pll_powerdown <= 1'b0;
            o_periph_idle <= '0;
            o_master_idle <= 2'b00;
        end else begin
            o_sysclk_enable <= state_r != ST_DEEP;
            o_pll_powerdown <= state_r == ST_DEEP &&
                               i_pll_powerdown_sel;
            o_periph_idle <= pstat_r[PERIPH_WIDTH-1:0];
            o_master_idle <= {mstat_r[`IDC_MBIT_HOST],
                              dma_idle && !auto_r};
        end
    end

    assign o_bus_error_irq = buserr_r;
    assign o_access_error = accerr_r;

    // Gate enables: CPU runs only in run state; memory only when selected.
    logic cpu_en;
    logic mem_en;
    assign cpu_en = state_r == ST_RUN;
    assign mem_en = mem_on && state_r != ST_DEEP;

    clock_gate_cell u_cpu_gate (
        .i_clock(i_clock),
        .i_enable(cpu_en),
        .o_gated_clock(o_cpu_clock)
    );
    clock_gate_cell u_mem_gate (
        .i_clock(i_clock),
        .i_enable(mem_en),
        .o_gated_clock(o_memif_clock)
    );

    // Assertions.
    sequence deep_cmd_s;
        idle_go && clk_req && !clk_valid;
    endsequence
    invalid_clk_err_a: assert property (@(posedge i_clock)
        disable iff (!i_nrst) deep_cmd_s |=> buserr_r)
        else $error("Invalid clock idle did not raise error.");
    valid_deep_a: assert property (@(posedge i_clock)
        disable iff (!i_nrst) (idle_go && clk_valid) |=> ##1 !o_sysclk_enable)
        else $error("Valid deep idle did not stop clock.");
    status_follow_a: assert property (@(posedge i_clock)
        disable iff (!i_nrst) (idle_go && !clk_req) |=>
        status_r == $past(config_r))
        else $error("Status did not take configuration.");
    reserved_zero_a: assert property (@(posedge i_clock)
        disable iff (!i_nrst) config_r[15:10] == 6'h00)
        else $error("Reserved configuration bits set.");
    no_early_idle_a: assert property (@(posedge i_clock)
        disable iff (!i_nrst) !idle_go |=> $stable(status_r) ||
        $past(state_r) != ST_RUN)
        else $error("Status changed without idle instruction.");
    light_wake_a: assert property (@(posedge i_clock)
        disable iff (!i_nrst) (state_r == ST_IDLE && wake_light) |=>
        !status_r[`IDC_BIT_CPU] && $stable(config_r))
        else $error("Light wake did not clear CPU status.");
    deep_hold_a: assert property (@(posedge i_clock)
        disable iff (!i_nrst) (state_r == ST_DEEP && !ext_irq_s) |=>
        state_r == ST_DEEP)
        else $error("Deep idle left without external interrupt.");
    mem_gate_a: assert property (@(negedge i_clock)
        disable iff (!i_nrst)
        $past(!xsel_r[`IDC_XBIT_MEMIF]) |-> !o_memif_clock)
        else $error("Memory clock enabled while unselected.");
    access_err_a: assert property (@(posedge i_clock)
        disable iff (!i_nrst) (i_memif_access && !mem_on) |=> accerr_r)
        else $error("Disabled access not flagged.");
    auto_end_a: assert property (@(posedge i_clock)
        disable iff (!i_nrst) (auto_r && done_s) |=> !auto_r)
        else $error("Auto transfer did not return to idle.");
endmodule : idle_domain_control

// ### sim/testbench.sv
// Self-checking bench for the idle domain controller.
`timescale 1ns/1ps
`include "idle_domain_control_defs.svh"
module testbench;
    import idle_domain_control_pkg::*;
    logic i_clock = 1'b0, i_nrst = 1'b0;
    logic [31:0] i_awaddr = 32'h0, i_wdata = 32'h0, i_araddr = 32'h0;
    logic [3:0] i_wstrb = 4'h3;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0, i_idle_instr = 1'b0;
    logic i_pll_powerdown_sel = 1'b0, i_serial_frame = 1'b0;
    logic [3:0] pins = 4'h0; // Irq, ext irq, access and done inputs.
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_cpu_clock;
    logic o_memif_clock, o_sysclk_enable, o_pll_powerdown, o_bus_error_irq;
    logic o_access_error;
    logic [1:0] o_bresp, o_rresp, o_master_idle;
    logic [31:0] o_rdata;
    logic [15:0] o_periph_idle;
    int n_fail = 0;
    int cmp_count = 0;
    // Free-running 250 MHz system clock.
    always #2 i_clock = ~i_clock;
    idle_domain_control dut (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_awaddr(i_awaddr),
        .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
        .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
        .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
        .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
        .i_rready(i_rready), .i_idle_instr(i_idle_instr),
        .i_unmasked_irq(pins[0]), .i_ext_irq(pins[1]),
        .i_pll_powerdown_sel(i_pll_powerdown_sel),
        .i_serial_frame(i_serial_frame), .i_serial_done(pins[3]),
        .i_memif_access(pins[2]), .o_cpu_clock(o_cpu_clock),
        .o_memif_clock(o_memif_clock), .o_sysclk_enable(o_sysclk_enable),
        .o_pll_powerdown(o_pll_powerdown), .o_bus_error_irq(o_bus_error_irq),
        .o_access_error(o_access_error), .o_periph_idle(o_periph_idle),
        .o_master_idle(o_master_idle)
    );
    // Counts one comparison and reports a mismatch at once.
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", what, e, g);
            n_fail++;
        end
    endtask : chk
    // Write of one register; both halves offered together.
    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        i_awaddr <= {14'h0000, idx, 2'b00};
        i_wdata <= {16'h0000, d};
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge i_clock);
            if (i_awvalid && o_awready) begin
                aw_ok = 1'b1;
                i_awvalid <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_ok = 1'b1;
                i_wvalid <= 1'b0;
            end
        end
        do @(posedge i_clock); while (o_bvalid !== 1'b1);
        chk("bresp", 32'h0, {30'h0, o_bresp});
        i_bready <= 1'b0;
    endtask : wr
    // Read of one register, compared with the data and response expected.
    task automatic rdchk(input logic [15:0] idx, input logic [31:0] e,
                         input logic [1:0] er);
        i_araddr <= {14'h0000, idx, 2'b00};
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do @(posedge i_clock); while (o_arready !== 1'b1);
        i_arvalid <= 1'b0;
        do @(posedge i_clock); while (o_rvalid !== 1'b1);
        chk("rdata", e, o_rdata);
        chk("rresp", {30'h0, er}, {30'h0, o_rresp});
        i_rready <= 1'b0;
    endtask : rdchk
    // One-cycle idle instruction, then time for the state to settle.
    task automatic go_idle();
        i_idle_instr <= 1'b1;
        @(posedge i_clock);
        i_idle_instr <= 1'b0;
        repeat (4) @(posedge i_clock);
    endtask : go_idle
    // Holds a level input high for a span, then drops it.
    task automatic pulse(input int k, input int n);
        pins[k] <= 1'b1;
        repeat (n) @(posedge i_clock);
        pins[k] <= 1'b0;
        repeat (8) @(posedge i_clock);
    endtask : pulse
    task automatic t_regs();
        rdchk(`IDC_IDX_CONFIG, 32'h0, 2'b00);
        rdchk(`IDC_IDX_STATUS, 32'h0, 2'b00);
        rdchk(16'h0020, 32'h0, 2'b10);
        wr(`IDC_IDX_CONFIG, 16'hffff);
        rdchk(`IDC_IDX_CONFIG, 32'h03ff, 2'b00);
        rdchk(`IDC_IDX_STATUS, 32'h0, 2'b00);
        chk("sysclk", 32'h1, {31'h0, o_sysclk_enable});
        wr(`IDC_IDX_CONFIG, 16'h0101);
        go_idle();
        rdchk(`IDC_IDX_STATUS, 32'h0101, 2'b00);
        #1 chk("cpu clk", 32'h0, {31'h0, o_cpu_clock});
        pulse(0, 1);
        rdchk(`IDC_IDX_STATUS, 32'h0, 2'b00);
        rdchk(`IDC_IDX_CONFIG, 32'h0101, 2'b00);
        $display("test regs and light idle done");
    endtask : t_regs
    task automatic t_clock_idle();
        wr(`IDC_IDX_CONFIG, 16'h0010);
        go_idle();
        chk("bus error", 32'h1, {31'h0, o_bus_error_irq});
        chk("sysclk", 32'h1, {31'h0, o_sysclk_enable});
        rdchk(`IDC_IDX_STATUS, 32'h0, 2'b00);
        wr(`IDC_IDX_EVENTS, 16'h0001);
        chk("bus error clr", 32'h0, {31'h0, o_bus_error_irq});
        wr(`IDC_IDX_CONFIG, 16'h03f6);
        go_idle();
        chk("bus error", 32'h1, {31'h0, o_bus_error_irq});
        wr(`IDC_IDX_EVENTS, 16'h0001);
        i_pll_powerdown_sel <= 1'b1;
        wr(`IDC_IDX_CONFIG, 16'h03f7);
        go_idle();
        chk("sysclk", 32'h0, {31'h0, o_sysclk_enable});
        chk("pll down", 32'h1, {31'h0, o_pll_powerdown});
        pulse(0, 2);
        chk("sysclk", 32'h0, {31'h0, o_sysclk_enable});
        pulse(1, 8);
        chk("sysclk", 32'h1, {31'h0, o_sysclk_enable});
        rdchk(`IDC_IDX_STATUS, 32'h0086, 2'b00);
        rdchk(`IDC_IDX_CONFIG, 32'h03f7, 2'b00);
        i_pll_powerdown_sel <= 1'b0;
        wr(`IDC_IDX_CONFIG, 16'h0000);
        go_idle();
        $display("test clock idle done");
    endtask : t_clock_idle
    task automatic t_memif();
        wr(`IDC_IDX_BUS_SELECT, 16'h0000);
        pulse(2, 1);
        chk("access err", 32'h1, {31'h0, o_access_error});
        rdchk(`IDC_IDX_EVENTS, 32'h2, 2'b00);
        #1 chk("memif clk", 32'h0, {31'h0, o_memif_clock});
        @(posedge i_clock);
        wr(`IDC_IDX_BUS_SELECT, 16'h0001);
        repeat (2) @(posedge i_clock);
        #1 chk("memif clk", 32'h1, {31'h0, o_memif_clock});
        @(posedge i_clock);
        $display("test memory interface done");
    endtask : t_memif
    task automatic t_ports();
        wr(`IDC_IDX_MASTER_CTRL, 16'h0001);
        wr(`IDC_IDX_CONFIG, 16'h0002);
        go_idle();
        chk("master", 32'h1, {30'h0, o_master_idle});
        rdchk(`IDC_IDX_MASTER_STAT, 32'h1, 2'b00);
        i_serial_frame <= 1'b1;
        repeat (8) @(posedge i_clock);
        chk("dma", 32'h0, {31'h0, o_master_idle[0]});
        i_serial_frame <= 1'b0;
        pulse(3, 4);
        chk("dma", 32'h1, {31'h0, o_master_idle[0]});
        wr(`IDC_IDX_PERIPH_CTRL, 16'h0005);
        rdchk(`IDC_IDX_PERIPH_STAT, 32'h0, 2'b00);
        wr(`IDC_IDX_CONFIG, 16'h0008);
        wr(`IDC_IDX_COMMAND, 16'h0001);
        rdchk(`IDC_IDX_PERIPH_STAT, 32'h5, 2'b00);
        chk("periph", 32'h5, {16'h0, o_periph_idle});
        $display("test ports done");
    endtask : t_ports
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done
    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (5000) @(posedge i_clock);
        n_fail++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge i_clock);
        i_nrst <= 1'b1;
        @(posedge i_clock);
        t_regs();
        t_clock_idle();
        t_memif();
        t_ports();
        test_done();
    end
endmodule : testbench
